// File: core/perf_mon_defs.vh
// constants for the framer performance counters and per-slot test logic
// assumes a 40 MHz system clock and 32-bit APB word addressing
`ifndef PERF_MON_DEFS_VH
`define PERF_MON_DEFS_VH

// register byte offsets
`define OFS_CONFIG     8'h00
`define OFS_LOOP1      8'h04
`define OFS_LOOP2      8'h08
`define OFS_LOOP3      8'h0C
`define OFS_LOOP4      8'h10
`define OFS_PATH_HI    8'h14
`define OFS_PATH_LO    8'h18
`define OFS_SYNC_HI    8'h1C
`define OFS_SYNC_LO    8'h20
`define OFS_FEBE_HI    8'h24
`define OFS_FEBE_LO    8'h28
`define OFS_TX_SEL     8'h2C
`define OFS_RX_SEL     8'h30
`define OFS_TX_BYTE    8'h34
`define OFS_RX_BYTE    8'h38
`define OFS_LINE_CNT   8'h3C

// counter_config field positions
`define CFG_EXZ        0
`define CFG_FBIT       1
`define CFG_FS         2
`define CFG_CV         3
`define CFG_E1         4
`define CFG_ESF        5
`define CFG_SUBST      6
`define CFG_CRC4       7
`define CFG_UPD_LO     8
`define CFG_UPD_HI     9
`define CFG_MANUAL     10

// update modes
`define UPD_SECOND     2'b00
`define UPD_SHORT      2'b01
`define UPD_MANUAL     2'b10

// reset values and the counter maximum
`define CONFIG_RST     11'h000
`define BYTE_RST       8'h00
`define COUNT_MAX      16'hFFFF

// update intervals in ms and the clock in kHz
`define UPD_SECOND_MS  1000
`define UPD_T1_MS      42
`define UPD_E1_MS      62
`define CLK_KHZ        40000

// zero-run thresholds
`define ZERO_RUN_PLAIN 5'd16
`define ZERO_RUN_SUBST 5'd8

`endif

// File: core/sat_counter.v
// saturating 16-bit error counter with a host-visible snapshot
// assumes inc and update are one-cycle pulses on clk
`include "perf_mon_defs.vh"

module sat_counter (
	input  wire        clk,
	input  wire        srst,
	input  wire        inc,
	input  wire        update,
	output reg  [15:0] held
);

	reg [15:0] running;

	// snapshot and restart; an event in the update cycle seeds the new count
	always @(posedge clk) begin
		if (srst) begin
			running <= 16'h0000;
			held    <= 16'h0000;
		end else if (update) begin
			held    <= running; // R22
			running <= {15'h0000, inc}; // R22
		end else if (inc && running != `COUNT_MAX) begin
			running <= running + 16'h0001; // R5 R10
		end
	end

endmodule // sat_counter

// File: core/line_code_check.v
// bipolar, code-violation and excess-zero detector for the receive line
// assumes one decoded symbol per bit_en; codeword flags a substitution bpv
`include "perf_mon_defs.vh"

module line_code_check (
	input  wire clk,
	input  wire srst,
	input  wire bit_en,
	input  wire mark,
	input  wire polarity,
	input  wire codeword,
	input  wire e1_mode,
	input  wire subst_en,
	input  wire count_zeros,
	input  wire cv_sel,
	output reg  violation
);

	reg       have_mark;
	reg       last_pol;
	reg       have_bpv;
	reg       last_bpv_pol;
	reg [4:0] zero_run;
	wire      bpv;
	wire      bpv_ok;
	wire      cv;
	wire      exz;
	wire [4:0] zlimit;

	// equal-polarity marks; codewords excluded only when substitution on
	assign bpv    = bit_en & mark & have_mark & (polarity == last_pol); // R8
	assign bpv_ok = bpv & ~(subst_en & codeword); // R6 R8
	assign cv     = bpv_ok & have_bpv & (polarity == last_bpv_pol); // R9
	assign zlimit = subst_en ? `ZERO_RUN_SUBST : `ZERO_RUN_PLAIN;
	assign exz    = bit_en & ~mark & count_zeros & ~e1_mode &
		(zero_run + 5'd1 == zlimit); // R6

	// polarity history and zero run length
	always @(posedge clk) begin
		if (srst) begin
			have_mark    <= 1'b0;
			last_pol     <= 1'b0;
			have_bpv     <= 1'b0;
			last_bpv_pol <= 1'b0;
			zero_run     <= 5'd0;
			violation    <= 1'b0;
		end else begin
			if (bit_en && mark) begin
				have_mark <= 1'b1;
				last_pol  <= polarity;
				zero_run  <= 5'd0;
			end else if (bit_en && zero_run != zlimit) begin
				zero_run <= zero_run + 5'd1; // one count per zero; holding at the limit counts each run once
			end
			if (bpv_ok) begin
				have_bpv     <= 1'b1;
				last_bpv_pol <= polarity;
			end
			if (e1_mode)
				violation <= cv_sel ? cv : bpv_ok; // R9
			else
				violation <= bpv_ok | exz; // R6
		end
	end

endmodule // line_code_check

// File: core/perf_mon.v
// performance counters, per-slot loopback and channel probes of a framer
// assumes framer event inputs are one-cycle pulses synchronous to clk,
// and that the host reaches the registers over a zero-wait APB slave
//
// Function
// [R1] a timeslot with its loopback bit set sends received data instead
// [R2] system keeps transmit and receive clocks and frame syncs aligned
// [R3] any set of timeslots may loop back; one select bit each
// [R4] counters update each second, every 42/62 ms, or manually; pulse out
// [R5] every error counter stops at its maximum, never wraps
// [R6] T1 line count: bipolar violations plus 16 or 8 zero runs
// [R7] line violation counter counts even while sync is lost
// [R8] E1 bipolar violation: equal-polarity marks, HDB3 codewords excluded
// [R9] E1 code-violation select counts successive same-polarity violations
// [R10] E1 line count holds at 65,535
// [R11] T1 path count: CRC6 under ESF, Ft (plus optional Fs) under D4
// [R12] T1 path count paused during receive sync loss
// [R13] E1 path count CRC4 errors, paused on FAS or CRC4 sync loss
// [R14] path count is 16 bits in high and low registers
// [R15] T1 multiframe mode counts out-of-sync multiframes, even in sync loss
// [R16] T1 F-bit mode counts Ft or FPS errors, paused in sync loss
// [R17] E1 counts FAS word errors, paused in sync loss or alignment search
// [R18] sync loss count is 16 bits in high and low registers
// [R19] E1 CRC4 counts zero far-end bits, paused on FAS/CRC4 sync loss
// [R20] one transmit and one receive timeslot captured into probe bytes
// [R21] probe selectors are five-bit zero-based channel indices
// [R22] each update copies running counts out and restarts them at zero
//
// The register offsets and the APB slave port were left to the implementer.
`include "perf_mon_defs.vh"

module perf_mon #(
	parameter SECOND_CYCLES = `UPD_SECOND_MS * `CLK_KHZ,
	parameter T1_CYCLES     = `UPD_T1_MS * `CLK_KHZ,
	parameter E1_CYCLES     = `UPD_E1_MS * `CLK_KHZ
) (
	input  wire        clk,
	input  wire        srst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// transmit timing and data
	input  wire        tx_bit_en,
	input  wire        transmit_sync_in,
	input  wire        backplane_tx_serial_in,
	output reg         tx_line_data,
	// receive timing and decoded line symbols
	input  wire        rx_bit_en,
	input  wire        rx_frame_start,
	input  wire        rx_data,
	input  wire        rx_mark,
	input  wire        rx_polarity,
	input  wire        rx_codeword,
	// framer error events
	input  wire        crc6_error,
	input  wire        ft_error,
	input  wire        fs_error,
	input  wire        fps_error,
	input  wire        crc4_error,
	input  wire        fas_word_error,
	input  wire        rx_multiframe,
	input  wire        ebit_strobe,
	input  wire        ebit_value,
	// framer sync state
	input  wire        rx_sync_lost,
	input  wire        fas_sync_lost,
	input  wire        crc4_sync_lost,
	input  wire        fas_search,
	input  wire        cas_search,
	input  wire        crc4_search,
	// update event, for the host timer interrupt
	output reg         counter_update_pulse
);

	reg  [10:0] counter_config;
	reg  [31:0] loopback_select;
	reg  [4:0]  tx_probe_index;
	reg  [4:0]  rx_probe_index;
	reg  [7:0]  tx_channel_probe_byte;
	reg  [7:0]  rx_channel_probe_byte;
	reg  [7:0]  tx_pos;
	reg  [7:0]  rx_pos;
	reg  [7:0]  tx_shift;
	reg  [7:0]  rx_shift;
	reg  [25:0] timer;
	reg         manual_req;
	reg  [25:0] timer_limit;
	reg         auto_tick;
	reg         path_inc;
	reg         sync_inc;
	reg         febe_inc;
	reg  [31:0] next_prdata;
	reg         addr_hit;
	wire        wr_en;
	wire        update;
	wire        line_inc;
	wire        e1;
	wire        esf;
	wire [1:0]  upd_mode;
	wire [4:0]  tx_slot;
	wire [4:0]  rx_slot;
	wire        tx_in_slot;
	wire        rx_in_slot;
	wire [15:0] line_violation_count;
	wire [15:0] path_error_count;
	wire [15:0] sync_loss_count;
	wire [15:0] far_end_error_count;
	wire [7:0]  tx_pos_now;
	wire [7:0]  rx_pos_now;
	wire        next_tx_line_data;

	// bit position to timeslot; T1 frames open with a framing bit
	function [4:0] slot_of;
		input [7:0] pos;
		input       e1_mode;
		reg   [7:0] p;
		begin
			p = e1_mode ? pos : pos - 8'd1;
			slot_of = p[7:3];
		end
	endfunction

	// true for payload bits; the T1 framing bit belongs to no slot
	function in_payload;
		input [7:0] pos;
		input       e1_mode;
		begin
			in_payload = e1_mode || pos != 8'd0;
		end
	endfunction

	// true on the last bit of a slot
	function last_bit;
		input [7:0] pos;
		input       e1_mode;
		reg   [7:0] p;
		begin
			p = e1_mode ? pos : pos - 8'd1;
			last_bit = (p[2:0] == 3'd7) && in_payload(pos, e1_mode);
		end
	endfunction

	assign e1       = counter_config[`CFG_E1];
	assign esf      = counter_config[`CFG_ESF];
	assign upd_mode = counter_config[`CFG_UPD_HI:`CFG_UPD_LO];

	// zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign wr_en   = psel & penable & pwrite & addr_hit;

	// register writes; manual update is a write-one pulse
	always @(posedge clk) begin
		if (srst) begin
			counter_config  <= `CONFIG_RST;
			loopback_select <= 32'h0000_0000;
			tx_probe_index  <= 5'h00;
			rx_probe_index  <= 5'h00;
			manual_req      <= 1'b0;
		end else begin
			manual_req <= 1'b0;
			if (wr_en) begin
				case (paddr)
				`OFS_CONFIG: begin
					counter_config <= {1'b0, pwdata[9:0]};
					manual_req     <= pwdata[`CFG_MANUAL]; // R4
				end
				`OFS_LOOP1: loopback_select[7:0]   <= pwdata[7:0]; // R3
				`OFS_LOOP2: loopback_select[15:8]  <= pwdata[7:0]; // R3
				`OFS_LOOP3: loopback_select[23:16] <= pwdata[7:0]; // R3
				`OFS_LOOP4: loopback_select[31:24] <= pwdata[7:0]; // R3
				`OFS_TX_SEL: tx_probe_index <= pwdata[4:0]; // R21
				`OFS_RX_SEL: rx_probe_index <= pwdata[4:0]; // R21
				default: ;
				endcase
			end
		end
	end

	// read mux; path, sync-loss and far-end counts split into high and low bytes
	always @* begin
		next_prdata = 32'h0000_0000;
		addr_hit    = 1'b1;
		case (paddr)
		`OFS_CONFIG:   next_prdata[9:0] = counter_config[9:0];
		`OFS_LOOP1:    next_prdata[7:0] = loopback_select[7:0];
		`OFS_LOOP2:    next_prdata[7:0] = loopback_select[15:8];
		`OFS_LOOP3:    next_prdata[7:0] = loopback_select[23:16];
		`OFS_LOOP4:    next_prdata[7:0] = loopback_select[31:24];
		`OFS_PATH_HI:  next_prdata[7:0] = path_error_count[15:8]; // R14
		`OFS_PATH_LO:  next_prdata[7:0] = path_error_count[7:0]; // R14
		`OFS_SYNC_HI:  next_prdata[7:0] = sync_loss_count[15:8]; // R18
		`OFS_SYNC_LO:  next_prdata[7:0] = sync_loss_count[7:0]; // R18
		`OFS_FEBE_HI:  next_prdata[7:0] = far_end_error_count[15:8];
		`OFS_FEBE_LO:  next_prdata[7:0] = far_end_error_count[7:0];
		`OFS_TX_SEL:   next_prdata[4:0] = tx_probe_index;
		`OFS_RX_SEL:   next_prdata[4:0] = rx_probe_index;
		`OFS_TX_BYTE:  next_prdata[7:0] = tx_channel_probe_byte;
		`OFS_RX_BYTE:  next_prdata[7:0] = rx_channel_probe_byte;
		`OFS_LINE_CNT: next_prdata[15:0] = line_violation_count;
		default:       addr_hit = 1'b0;
		endcase
	end

	// read data held in a flop, loaded in the setup cycle
	always @(posedge clk) begin
		if (srst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
	end

	// short update interval follows the line mode
	always @* begin
		if (upd_mode == `UPD_SHORT)
			timer_limit = e1 ? E1_CYCLES[25:0] : T1_CYCLES[25:0]; // R4
		else
			timer_limit = SECOND_CYCLES[25:0]; // R4
	end

	// interval timer; restarts when it expires
	always @(posedge clk) begin
		if (srst) begin
			timer     <= 26'd0;
			auto_tick <= 1'b0;
		end else if (upd_mode == `UPD_MANUAL) begin
			timer     <= 26'd0;
			auto_tick <= 1'b0;
		end else if (timer >= timer_limit - 26'd1) begin
			timer     <= 26'd0;
			auto_tick <= 1'b1; // R4
		end else begin
			timer     <= timer + 26'd1;
			auto_tick <= 1'b0;
		end
	end

	// a manual request also works in automatic modes
	assign update = auto_tick | manual_req; // R4

	// update pulse shown to the host, raised on the same edge as the snapshot
	always @(posedge clk) begin
		if (srst)
			counter_update_pulse <= 1'b0;
		else
			counter_update_pulse <= update; // R4
	end

	// transmit bit position; sync marks the frame's first bit
	assign tx_pos_now = transmit_sync_in ? 8'd0 : tx_pos;
	always @(posedge clk) begin
		if (srst)
			tx_pos <= 8'd0;
		else if (tx_bit_en)
			tx_pos <= tx_pos_now + 8'd1;
	end

	assign tx_slot    = slot_of(tx_pos_now, e1);
	assign tx_in_slot = in_payload(tx_pos_now, e1);

	// outgoing bit for the current transmit slot, after loopback
	assign next_tx_line_data = (tx_in_slot && loopback_select[tx_slot]) ?
		rx_data : backplane_tx_serial_in; // R1 R3

	// loopback relies on receive bits arriving aligned with transmit ones
	always @(posedge clk) begin
		if (srst)
			tx_line_data <= 1'b0;
		else if (tx_bit_en)
			tx_line_data <= next_tx_line_data; // R1 R2
	end

	// receive bit position
	assign rx_pos_now = rx_frame_start ? 8'd0 : rx_pos;
	always @(posedge clk) begin
		if (srst)
			rx_pos <= 8'd0;
		else if (rx_bit_en)
			rx_pos <= rx_pos_now + 8'd1;
	end

	assign rx_slot    = slot_of(rx_pos_now, e1);
	assign rx_in_slot = in_payload(rx_pos_now, e1);

	// probe capture: shift bits, latch the byte at the slot's last bit
	always @(posedge clk) begin
		if (srst) begin
			tx_shift              <= `BYTE_RST;
			rx_shift              <= `BYTE_RST;
			tx_channel_probe_byte <= `BYTE_RST;
			rx_channel_probe_byte <= `BYTE_RST;
		end else begin
			if (tx_bit_en) begin
				tx_shift <= {tx_shift[6:0], next_tx_line_data};
				if (last_bit(tx_pos_now, e1) && tx_slot == tx_probe_index)
					tx_channel_probe_byte <=
						{tx_shift[6:0], next_tx_line_data}; // R20
			end
			if (rx_bit_en) begin
				rx_shift <= {rx_shift[6:0], rx_data};
				if (last_bit(rx_pos_now, e1) && rx_in_slot &&
					rx_slot == rx_probe_index)
					rx_channel_probe_byte <= {rx_shift[6:0], rx_data}; // R20
			end
		end
	end

	// path event selection and qualification
	always @* begin
		if (e1)
			path_inc = crc4_error & ~fas_sync_lost & ~crc4_sync_lost; // R13
		else if (esf)
			path_inc = crc6_error & ~rx_sync_lost; // R11 R12
		else
			path_inc = (ft_error | (fs_error & counter_config[`CFG_FS])) &
				~rx_sync_lost; // R11 R12
	end

	// out-of-sync event selection
	always @* begin
		if (e1)
			sync_inc = fas_word_error & ~rx_sync_lost & ~fas_search &
				~cas_search & ~crc4_search; // R17
		else if (!counter_config[`CFG_FBIT])
			sync_inc = rx_multiframe & rx_sync_lost; // R15
		else
			sync_inc = (esf ? fps_error : ft_error) & ~rx_sync_lost; // R16
	end

	// far-end error bits, only with E1 CRC4 multiframing
	always @* begin
		febe_inc = e1 & counter_config[`CFG_CRC4] & ebit_strobe &
			~ebit_value & ~fas_sync_lost & ~crc4_sync_lost; // R19
	end

	// line code checker is never gated by sync state
	line_code_check u_line (
		.clk         (clk),
		.srst        (srst),
		.bit_en      (rx_bit_en),
		.mark        (rx_mark),
		.polarity    (rx_polarity),
		.codeword    (rx_codeword),
		.e1_mode     (e1),
		.subst_en    (counter_config[`CFG_SUBST]),
		.count_zeros (counter_config[`CFG_EXZ]),
		.cv_sel      (counter_config[`CFG_CV]),
		.violation   (line_inc)
	); // R7

	sat_counter u_line_cnt (
		.clk    (clk),
		.srst   (srst),
		.inc    (line_inc),
		.update (update),
		.held   (line_violation_count)
	);

	sat_counter u_path_cnt (
		.clk    (clk),
		.srst   (srst),
		.inc    (path_inc),
		.update (update),
		.held   (path_error_count)
	);

	sat_counter u_sync_cnt (
		.clk    (clk),
		.srst   (srst),
		.inc    (sync_inc),
		.update (update),
		.held   (sync_loss_count)
	);

	sat_counter u_febe_cnt (
		.clk    (clk),
		.srst   (srst),
		.inc    (febe_inc),
		.update (update),
		.held   (far_end_error_count)
	);

endmodule // perf_mon

// File: bench/perf_mon_checker.sv
// assertions on the host bus and update pulse of the counter block
// assumes it is bound to perf_mon and sees only that module's ports
module perf_mon_checker (
	input wire        clk,
	input wire        srst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        counter_update_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        rd, wr, man, hold_ok;
	logic [7:0]  loop1;
	logic [1:0]  mode;
	logic [31:0] lo_seen;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// completed host accesses
	assign rd = psel && penable && !pwrite;
	assign wr = psel && penable && pwrite;
	assign man = wr && paddr == 8'h00 && pwdata[10];
	// shadows of host writes and of the last low path byte read; any update or config write voids that byte
	always @(posedge clk) begin
		if (srst) begin
			loop1 <= 8'h00;
			mode <= 2'h0;
			hold_ok <= 1'b0;
			lo_seen <= 32'h0000_0000;
		end else begin
			if (wr && paddr == 8'h04)
				loop1 <= pwdata[7:0];
			if (wr && paddr == 8'h00)
				mode <= pwdata[9:8];
			if (rd && paddr == 8'h18)
				lo_seen <= prdata;
			if (counter_update_pulse || (wr && paddr == 8'h00))
				hold_ok <= 1'b0;
			else if (rd && paddr == 8'h18)
				hold_ok <= 1'b1;
		end
	end
	property p_pulse_one;
		counter_update_pulse |=> !counter_update_pulse;
	endproperty
	a_pulse_one: assert property (p_pulse_one)
		else $error("update pulse longer than one cycle");
	property p_manual;
		$rose(counter_update_pulse) && mode == 2'h2 |-> $past(man) || $past(man, 2);
	endproperty
	a_manual: assert property (p_manual)
		else $error("update pulse without a manual request");
	property p_path;
		rd && (paddr == 8'h14 || paddr == 8'h18) |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_path: assert property (p_path)
		else $error("path count byte too wide");
	property p_sync;
		rd && (paddr == 8'h1C || paddr == 8'h20) |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync loss count byte too wide");
	property p_febe;
		rd && (paddr == 8'h24 || paddr == 8'h28) |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_febe: assert property (p_febe)
		else $error("far end count byte too wide");
	property p_line;
		rd && paddr == 8'h3C |-> prdata[31:16] == 16'h0000;
	endproperty
	a_line: assert property (p_line)
		else $error("line count wider than 16 bits");
	property p_loop;
		rd && paddr == 8'h04 |-> prdata == {24'h00_0000, loop1};
	endproperty
	a_loop: assert property (p_loop)
		else $error("loopback select readback wrong");
	property p_hold;
		rd && paddr == 8'h18 && hold_ok |-> prdata == lo_seen;
	endproperty
	a_hold: assert property (p_hold)
		else $error("snapshot moved between updates");
endmodule // perf_mon_checker

bind perf_mon perf_mon_checker perf_mon_checker_inst (.clk(clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata),
	.counter_update_pulse(counter_update_pulse));

// File: bench/framer_stub.sv
// framer timing stub: shared tx and rx bit timing, sync and data
// assumes one line bit every four system clocks
module framer_stub (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       e1,
	output logic            bit_en,
	output logic            fsync,
	output logic            rx_data,
	output logic            bp_data,
	output logic [7:0]      pos
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div;
	// one timing source for both ways, as loopback demands
	always @(posedge clk) begin
		div <= srst ? 2'h0 : div + 2'h1;
		bit_en <= !srst && div == 2'h3;
		if (srst)
			pos <= 8'h00;
		else if (bit_en)
			pos <= (!e1 && pos == 8'hC0) ? 8'h00 : pos + 8'h01;
	end
	// data alternates each bit within a slot, odd slots inverted, so a stuck output cannot pass
	assign fsync = bit_en && pos == 8'h00;
	assign rx_data = pos[0] ^ pos[3];
	assign bp_data = !rx_data;
endmodule // framer_stub

// File: bench/t1e1_perf_counters_loopback_tb.sv
// bench top: host bus, framer events and loopback checks
// assumes framer_stub supplies aligned transmit and receive timing
module t1e1_perf_counters_loopback_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SEC = 200;
	localparam int T1N = 20;
	localparam int E1N = 30;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic        tx_line_data, pulse, e1, ebv, bit_en, fsync, rx_data, bp_data;
	logic        mk, pl, cw;
	logic [7:0]  paddr, ev, pos;
	logic [5:0]  lv;
	logic [31:0] pwdata, prdata, q;
	int          failures, cmp_count;
	framer_stub framer_stub_inst (.clk(clk), .srst(srst), .e1(e1),
		.bit_en(bit_en), .fsync(fsync), .rx_data(rx_data), .bp_data(bp_data),
		.pos(pos));
	perf_mon #(.SECOND_CYCLES(SEC), .T1_CYCLES(T1N), .E1_CYCLES(E1N))
	perf_mon_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .tx_bit_en(bit_en),
		.transmit_sync_in(fsync), .backplane_tx_serial_in(bp_data),
		.tx_line_data(tx_line_data), .rx_bit_en(bit_en),
		.rx_frame_start(fsync), .rx_data(rx_data), .rx_mark(mk),
		.rx_polarity(pl), .rx_codeword(cw), .crc6_error(ev[0]),
		.ft_error(ev[1]), .fs_error(ev[2]), .fps_error(ev[3]),
		.crc4_error(ev[4]), .fas_word_error(ev[5]), .rx_multiframe(ev[6]),
		.ebit_strobe(ev[7]), .ebit_value(ebv), .rx_sync_lost(lv[0]),
		.fas_sync_lost(lv[1]), .crc4_sync_lost(lv[2]), .fas_search(lv[3]),
		.cas_search(lv[4]), .crc4_search(lv[5]),
		.counter_update_pulse(pulse));
	// free-running 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk);
		while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			failures++;
			close_out();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk16(input logic [7:0] a, input logic [15:0] v);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, {24'h00_0000, v[15:8]});
		apb(1'b0, a + 8'h04, 32'h0000_0000);
		chk(q, {24'h00_0000, v[7:0]});
	endtask
	task automatic fire(input logic [7:0] m, input int n);
		repeat (n) begin
			ev <= m;
			@(posedge clk);
			ev <= 8'h00;
			@(posedge clk);
		end
	endtask
	task automatic test_regs;
		apb(1'b1, 8'h00, 32'h0000_0210);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'h0000_00FF);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
	endtask
	task automatic test_loop;
		logic [31:0] mask;
		logic        exp;
		mask = 32'h8000_00A5;
		apb(1'b1, 8'h04, 32'h0000_00A5);
		apb(1'b1, 8'h10, 32'h0000_0080);
		apb(1'b1, 8'h2C, 32'h0000_0001);
		apb(1'b1, 8'h30, 32'h0000_0003);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(q, 32'h0000_00A5);
		repeat (1100) begin
			@(posedge clk);
			if (bit_en === 1'b1) begin
				exp = mask[pos[7:3]] ? rx_data : bp_data;
				@(negedge clk);
				chk({31'h0, tx_line_data}, {31'h0, exp});
			end
		end
		// back onto the rising edge before the next bus transfer
		@(posedge clk);
		apb(1'b0, 8'h34, 32'h0000_0000);
		chk(q, 32'h0000_0055);
		apb(1'b0, 8'h38, 32'h0000_0000);
		chk(q, 32'h0000_00AA);
	endtask
	task automatic test_e1;
		apb(1'b1, 8'h00, 32'h0000_0690);
		fire(8'hB0, 5);
		lv <= 6'h0B;
		fire(8'hB0, 2);
		lv <= 6'h10;
		fire(8'hB0, 1);
		lv <= 6'h00;
		ebv <= 1'b1;
		fire(8'h80, 2);
		ebv <= 1'b0;
		apb(1'b1, 8'h00, 32'h0000_0690);
		chk16(8'h14, 16'h0006);
		chk16(8'h14, 16'h0006);
		chk16(8'h1C, 16'h0005);
		chk16(8'h24, 16'h0006);
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0690);
		chk16(8'h14, 16'h0000);
	endtask
	// ten equal-polarity marks give nine violations, even in sync loss
	task automatic test_line;
		apb(1'b1, 8'h00, 32'h0000_0690);
		lv <= 6'h01;
		{mk, pl} <= 2'h3;
		repeat (40) @(posedge clk);
		{mk, pl, lv} <= 8'h00;
		apb(1'b1, 8'h00, 32'h0000_06D0);
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk(q, 32'h0000_0009);
		{mk, cw} <= 2'h3;
		repeat (40) @(posedge clk);
		{mk, cw} <= 2'h0;
		apb(1'b1, 8'h00, 32'h0000_06D0);
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk(q, 32'h0000_0000);
	endtask
	task automatic test_t1;
		apb(1'b1, 8'h00, 32'h0000_0600);
		lv <= 6'h01;
		fire(8'h40, 3);
		lv <= 6'h00;
		fire(8'h40, 2);
		apb(1'b1, 8'h00, 32'h0000_0622);
		chk16(8'h1C, 16'h0003);
		fire(8'h09, 2);
		lv <= 6'h01;
		fire(8'h09, 3);
		lv <= 6'h00;
		fire(8'h01, 1);
		apb(1'b1, 8'h00, 32'h0000_0622);
		chk16(8'h1C, 16'h0002);
		chk16(8'h14, 16'h0003);
		apb(1'b1, 8'h00, 32'h0000_0604);
		fire(8'h02, 1);
		fire(8'h04, 1);
		apb(1'b1, 8'h00, 32'h0000_0604);
		chk16(8'h14, 16'h0002);
		apb(1'b1, 8'h00, 32'h0000_0690);
		ev <= 8'h10;
		repeat (65540) @(posedge clk);
		ev <= 8'h00;
		apb(1'b1, 8'h00, 32'h0000_0690);
		chk16(8'h14, 16'hFFFF);
	endtask
	task automatic test_timer;
		int k, j, gap;
		int per[3];
		per = '{SEC, T1N, E1N};
		for (k = 0; k < 3; k++) begin
			apb(1'b1, 8'h00, (k == 2) ? 32'h0000_0110 :
				(k == 1) ? 32'h0000_0100 : 32'h0000_0000);
			for (j = 0; j < 2; j++) begin
				gap = 0;
				do @(posedge clk);
				while (pulse !== 1'b1 && ++gap < 300);
				if (gap >= 300) begin
					failures++;
					close_out();
				end
			end
			chk(gap + 1, per[k]);
		end
	endtask
	// main sequence
	initial begin
		{srst, e1} = 2'h3;
		{psel, penable, pwrite, ebv} = 4'h0;
		{mk, pl, cw} = 3'h0;
		{paddr, ev, lv} = 22'h00_0000;
		pwdata = 32'h0000_0000;
		failures = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		test_regs();
		test_loop();
		test_e1();
		test_line();
		test_t1();
		test_timer();
		close_out();
	end
endmodule // t1e1_perf_counters_loopback_tb
